// ---- hdl/ssd_diag_regs.sv ----
module ssd_diag_regs (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_arst_n,
    // Fault capture
    input wire logic [ssd_pkg::N_SRC-1:0] i_set,
    input wire logic i_clear,
    output logic [ssd_pkg::N_SRC-1:0] o_flags,
    // Read port
    input wire logic i_rd,
    input wire logic [ssd_pkg::IDX_W-1:0] i_idx,
    output logic [ssd_pkg::REG_W-1:0] o_rdata,
    output logic o_rvalid
);
    import ssd_pkg::*;

    logic [N_SRC-1:0] flags_q;
    logic [REG_W-1:0] rdata_d;
    logic [REG_W-1:0] rdata_q;
    logic rvalid_q;

    // Sticky flags; a fault in the clearing cycle survives the clear
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            flags_q <= '0;
        end else begin
            flags_q <= (i_clear ? '0 : flags_q) | i_set;
        end
    end

    // Read mux; reserved and unused bits are zero
    always_comb begin
        rdata_d = '0;
        case (i_idx)
            IDX_RELAY_LO: rdata_d = {flags_q[RELAY9_SRC], flags_q[SRC_AUX_BASE +: N_AUX],
                flags_q[LO_RELAY_N-1:0], {LO_RSVD_W{1'b0}}};
            IDX_RELAY_HI: rdata_d = {1'b0, flags_q[HI_RELAY_SRC +: HI_RELAY_N]};
            IDX_INTERNAL: rdata_d = {{(REG_W-N_INT){1'b0}},
                flags_q[SRC_INT_BASE +: N_INT]};
            default: rdata_d = '0;
        endcase
    end

    // Read data stands until the next read
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rdata_q <= '0;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= i_rd;
            if (i_rd) begin
                rdata_q <= rdata_d;
            end
        end
    end

    assign o_flags = flags_q;
    assign o_rdata = rdata_q;
    assign o_rvalid = rvalid_q;

    chk_flag_sticky: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (flags_q != '0 && !i_clear) |=> ((flags_q & $past(flags_q)) == $past(flags_q)))
        else $error("fault flag dropped without reset");
    chk_reserved_zero: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (i_rd && i_idx == IDX_RELAY_LO) |=> (rdata_q[LO_RSVD_W-1:0] == '0))
        else $error("reserved bits not zero");
endmodule : ssd_diag_regs

// ---- hdl/ssd_pkg.sv ----
package ssd_pkg;
    // ************************************************************
    // Source counts and alarm groups
    // ************************************************************
    localparam int N_RELAY = 24;
    localparam int N_AUX = 5;
    localparam int N_INT = 10;
    localparam int N_SRC = N_RELAY + N_AUX + N_INT;
    localparam int SRC_AUX_BASE = N_RELAY;
    localparam int SRC_INT_BASE = N_RELAY + N_AUX;
    localparam int N_GRP = 3;
    localparam int GRP_W = 2;
    localparam int N_OUT = 8;
    localparam int SRC_IDX_W = 6;
    localparam logic [N_GRP-1:0] SF_LINK_RST = 3'h2;

    // ************************************************************
    // Diagnostic register map (index on the read port)
    // ************************************************************
    localparam int REG_W = 16;
    localparam int IDX_W = 2;
    localparam logic [IDX_W-1:0] IDX_RELAY_LO = 2'h0;
    localparam logic [IDX_W-1:0] IDX_RELAY_HI = 2'h1;
    localparam logic [IDX_W-1:0] IDX_SPARE = 2'h2;
    localparam logic [IDX_W-1:0] IDX_INTERNAL = 2'h3;
    localparam int LO_RSVD_W = 2;
    localparam int LO_RELAY_N = 8;
    localparam int RELAY9_SRC = 8;
    localparam int HI_RELAY_N = 15;
    localparam int HI_RELAY_SRC = 9;

    // ************************************************************
    // Events and timing
    // ************************************************************
    localparam logic [7:0] EV_TEMP_ON = 8'h38;
    localparam logic [7:0] EV_TEMP_OFF = 8'h39;
    localparam int CLK_PERIOD_NS = 4;
    localparam int WD_TIMEOUT_NS = 1000000;
    localparam int WD_RESTART_NS = 4000000;
    localparam int WD_PULSE_NS = 1000;
    localparam int WD_TIMEOUT_CYC = (WD_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WD_RESTART_CYC = (WD_RESTART_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WD_PULSE_CYC = (WD_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {ST_BOOT, ST_RUN, ST_PERM} ssd_state_t;
    typedef enum logic [1:0] {WD_WATCH, WD_RESTART, WD_DEAD} ssd_wd_state_t;
endpackage : ssd_pkg

// ---- hdl/ssd_top.sv ----
// Notes on behaviour
// - Watchdog supervises controller and attempts restart
// - Failed restart flags a permanent internal fault
// - Permanent fault blocks all relays but self-supervision
// - Fail output energised only when supplied, operational
// - Sources map to three groups, groups link to output
// - Default: only group two drives fail output
// - Group signals routed per group via output matrix
// - Self-tests at boot, checking continues while running
// - Permanent state: drop output, lamp on, panel message
// - Temporary fault: matrix signal, on event, off event
// - Four sixteen-bit read-only diagnostic registers
// - Register one and two carry relay fault bits
// - Register four low bits: supply, bus, code, card, logic
// - Register four bits five to nine: arc, memory, supply
// - Events carry the faulting source code
module ssd_top #(
    parameter int WD_TIMEOUT = ssd_pkg::WD_TIMEOUT_CYC,
    parameter int WD_RESTART = ssd_pkg::WD_RESTART_CYC
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_arst_n,
    // Controller and boot test pins
    input wire logic i_heartbeat,
    input wire logic i_boot_done,
    input wire logic i_boot_pass,
    input wire logic i_aux_supply_ok,
    output logic o_ctrl_restart,
    // Fault source pins
    input wire logic [ssd_pkg::N_RELAY-1:0] i_relay_fault,
    input wire logic [ssd_pkg::N_AUX-1:0] i_aux_fault,
    input wire logic [ssd_pkg::N_INT-1:0] i_internal_fault,
    // Local panel
    input wire logic i_hmi_reset,
    output logic o_status_led,
    output logic o_panel_fault,
    // Configuration
    input wire logic i_cfg_load,
    input wire logic [ssd_pkg::N_SRC*ssd_pkg::GRP_W-1:0] i_cfg_group,
    input wire logic [ssd_pkg::N_GRP-1:0] i_cfg_sf_link,
    input wire logic [ssd_pkg::N_GRP*ssd_pkg::N_OUT-1:0] i_cfg_matrix,
    // Output contacts
    input wire logic [ssd_pkg::N_RELAY-1:0] i_relay_cmd,
    input wire logic [ssd_pkg::N_AUX-1:0] i_aux_cmd,
    output logic [ssd_pkg::N_RELAY-1:0] o_relay_drive,
    output logic [ssd_pkg::N_AUX-1:0] o_aux_drive,
    output logic o_fail_status,
    // Alarm groups and matrix
    output logic [ssd_pkg::N_GRP-1:0] o_group_active,
    output logic [ssd_pkg::N_OUT-1:0] o_matrix_out,
    output logic o_temp_fault,
    // Events
    output logic o_event_valid,
    output logic [7:0] o_event_code,
    output logic [ssd_pkg::SRC_IDX_W-1:0] o_event_src,
    // Remote diagnostic read port
    input wire logic i_reg_rd,
    input wire logic [ssd_pkg::IDX_W-1:0] i_reg_idx,
    output logic [ssd_pkg::REG_W-1:0] o_reg_rdata,
    output logic o_reg_rvalid
);
    import ssd_pkg::*;

    localparam int PIN_W = 4;

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic [N_SRC-1:0] src_meta_q;
    logic [N_SRC-1:0] src_q;
    logic [PIN_W-1:0] pin_meta_q;
    logic [PIN_W-1:0] pin_q;
    logic beat_prev_q;
    logic kick;
    logic boot_done;
    logic boot_pass;
    logic supply_ok;

    // Two flops on each fault source and controller, boot and supply pin before any logic looks at it
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            src_meta_q <= '0;
            src_q <= '0;
            pin_meta_q <= '0;
            pin_q <= '0;
        end else begin
            src_meta_q <= {i_internal_fault, i_aux_fault, i_relay_fault};
            src_q <= src_meta_q;
            pin_meta_q <= {i_aux_supply_ok, i_boot_pass, i_boot_done, i_heartbeat};
            pin_q <= pin_meta_q;
        end
    end

    // Heartbeat edge is the controller's sign of life
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            beat_prev_q <= 1'b0;
        end else begin
            beat_prev_q <= pin_q[0];
        end
    end

    assign kick = pin_q[0] ^ beat_prev_q;
    assign boot_done = pin_q[1];
    assign boot_pass = pin_q[2];
    assign supply_ok = pin_q[3];

    // ************************************************************
    // Configuration
    // ************************************************************
    logic [N_SRC*GRP_W-1:0] grp_map_q;
    logic [N_GRP-1:0] sf_link_q;
    logic [N_GRP*N_OUT-1:0] matrix_q;
    logic cfg_seen_q;

    // Settings load as one block so the mapping never tears
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            grp_map_q <= '0;
            sf_link_q <= SF_LINK_RST;
            matrix_q <= '0;
            cfg_seen_q <= 1'b0;
        end else if (i_cfg_load) begin
            grp_map_q <= i_cfg_group;
            sf_link_q <= i_cfg_sf_link;
            matrix_q <= i_cfg_matrix;
            cfg_seen_q <= 1'b1;
        end
    end

    // ************************************************************
    // Diagnostic flags and registers
    // ************************************************************
    logic [N_SRC-1:0] flags;

    ssd_diag_regs u_regs (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_set(src_q),
        .i_clear(i_hmi_reset),
        .o_flags(flags),
        .i_rd(i_reg_rd),
        .i_idx(i_reg_idx),
        .o_rdata(o_reg_rdata),
        .o_rvalid(o_reg_rvalid)
    );

    // ************************************************************
    // Group decode
    // ************************************************************
    logic [N_GRP-1:0][N_SRC-1:0] grp_mask;
    logic [N_SRC-1:0] src_mapped;
    logic [N_GRP-1:0] grp_d;

    // Each source belongs to at most one group, code zero is none
    genvar g;
    genvar s;
    generate
        for (g = 0; g < N_GRP; g++) begin : g_grp
            for (s = 0; s < N_SRC; s++) begin : g_src
                assign grp_mask[g][s] = (grp_map_q[s*GRP_W +: GRP_W] == GRP_W'(g + 1));
            end
            assign grp_d[g] = |(flags & grp_mask[g]);
        end
        for (s = 0; s < N_SRC; s++) begin : g_map
            assign src_mapped[s] = (grp_map_q[s*GRP_W +: GRP_W] != '0);
        end
    endgenerate

    // ************************************************************
    // Controller supervision and boot
    // ************************************************************
    ssd_state_t st_q;
    logic wd_perm;
    logic wd_restart;

    ssd_watchdog #(
        .TIMEOUT_CYC(WD_TIMEOUT),
        .RESTART_CYC(WD_RESTART),
        .PULSE_CYC(WD_PULSE_CYC)
    ) u_wd (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_enable(st_q == ST_RUN),
        .i_kick(kick),
        .o_restart(wd_restart),
        .o_perm(wd_perm)
    );

    // Boot tests gate entry to running; permanent state is left only by reset
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st_q <= ST_BOOT;
        end else begin
            case (st_q)
                ST_BOOT: begin
                    if (boot_done) begin
                        st_q <= boot_pass ? ST_RUN : ST_PERM;
                    end
                end
                ST_RUN: begin
                    if (wd_perm) begin
                        st_q <= ST_PERM;
                    end
                end
                ST_PERM: st_q <= ST_PERM;
                default: st_q <= ST_BOOT;
            endcase
        end
    end

    // ************************************************************
    // Output contacts and indicators
    // ************************************************************
    logic perm;
    logic sf_hit;
    logic relay_block_q;
    logic [N_RELAY-1:0] relay_drive_q;
    logic [N_AUX-1:0] aux_drive_q;
    logic fail_q;
    logic led_q;
    logic panel_q;
    logic restart_q;

    assign perm = (st_q == ST_PERM);
    assign sf_hit = |(o_group_active & sf_link_q);

    // Contacts drop one cycle after the fault so no command slips through
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            relay_drive_q <= '0;
            aux_drive_q <= '0;
            relay_block_q <= 1'b0;
        end else begin
            relay_block_q <= perm;
            relay_drive_q <= perm ? '0 : i_relay_cmd;
            aux_drive_q <= perm ? '0 : i_aux_cmd;
        end
    end

    // Working-current output: any doubt leaves it de-energised
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            fail_q <= 1'b0;
        end else begin
            fail_q <= supply_ok && (st_q == ST_RUN) && !sf_hit;
        end
    end

    // Lamp and panel message latch with the permanent state
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            led_q <= 1'b0;
            panel_q <= 1'b0;
            restart_q <= 1'b0;
        end else begin
            led_q <= perm;
            panel_q <= perm;
            restart_q <= wd_restart;
        end
    end

    assign o_relay_drive = relay_drive_q;
    assign o_aux_drive = aux_drive_q;
    assign o_fail_status = fail_q;
    assign o_status_led = led_q;
    assign o_panel_fault = panel_q;
    assign o_ctrl_restart = restart_q;

    // ************************************************************
    // Group signals and output matrix
    // ************************************************************
    logic [N_GRP-1:0] grp_q;
    logic [N_OUT-1:0] mat_q;

    // Group signals hold until the panel reset clears the flags
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            grp_q <= '0;
        end else begin
            grp_q <= grp_d;
        end
    end

    genvar o;
    generate
        for (o = 0; o < N_OUT; o++) begin : g_out
            always_ff @(posedge i_clk or negedge i_arst_n) begin
                if (!i_arst_n) begin
                    mat_q[o] <= 1'b0;
                end else begin
                    mat_q[o] <= |(grp_q & {matrix_q[2*N_OUT+o], matrix_q[N_OUT+o],
                        matrix_q[o]});
                end
            end
        end
    endgenerate

    assign o_group_active = grp_q;
    assign o_matrix_out = mat_q;

    // ************************************************************
    // Temporary fault events
    // ************************************************************
    logic temp_q;
    logic temp_prev_q;
    logic ev_valid_q;
    logic [7:0] ev_code_q;
    logic [SRC_IDX_W-1:0] ev_src_q;

    // Lowest active source names the event
    function automatic logic [SRC_IDX_W-1:0] ssd_first(input logic [N_SRC-1:0] v);
        logic [SRC_IDX_W-1:0] r;
        r = '0;
        for (int i = N_SRC - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = SRC_IDX_W'(i);
            end
        end
        return r;
    endfunction : ssd_first

    // Live condition, not the latch, so the off event can follow
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            temp_q <= 1'b0;
            temp_prev_q <= 1'b0;
        end else begin
            temp_q <= |(src_q & src_mapped);
            temp_prev_q <= temp_q;
        end
    end

    // The off event keeps the source code of the matching on event
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ev_valid_q <= 1'b0;
            ev_code_q <= '0;
            ev_src_q <= '0;
        end else begin
            ev_valid_q <= temp_q ^ temp_prev_q;
            if (temp_q && !temp_prev_q) begin
                ev_code_q <= EV_TEMP_ON;
                ev_src_q <= ssd_first(src_q & src_mapped);
            end else if (!temp_q && temp_prev_q) begin
                ev_code_q <= EV_TEMP_OFF;
            end
        end
    end

    assign o_temp_fault = temp_q;
    assign o_event_valid = ev_valid_q;
    assign o_event_code = ev_code_q;
    assign o_event_src = ev_src_q;

    // ************************************************************
    // Checks
    // ************************************************************
    chk_perm_blocks: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        perm |=> (o_relay_drive == '0 && o_aux_drive == '0))
        else $error("relay driven in permanent fault");
    chk_perm_signals: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        perm |=> (!o_fail_status && o_status_led && o_panel_fault))
        else $error("permanent state not shown");
    chk_supply_loss: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        !supply_ok |=> !o_fail_status)
        else $error("fail output held without supply");
    chk_boot_hold: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (st_q == ST_BOOT && !boot_done) |=> ((st_q == ST_BOOT) ##0 !o_fail_status [*2]))
        else $error("left boot before self-test");
    chk_sf_default: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        !cfg_seen_q |-> (sf_link_q == SF_LINK_RST))
        else $error("default group link lost");
    chk_group_drop: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (st_q == ST_RUN && supply_ok && (grp_q & sf_link_q) != '0) |=> !o_fail_status)
        else $error("linked group did not drop output");
    chk_matrix_route: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (grp_q[0] && matrix_q[0]) |=> o_matrix_out[0])
        else $error("group signal not routed");
    chk_event_on: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        $rose(temp_q) |=> (o_event_valid && o_event_code == EV_TEMP_ON)
        ##1 (!o_event_valid || o_event_code == EV_TEMP_OFF))
        else $error("missing on event");
    chk_event_off: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        $fell(temp_q) |=> (o_event_valid && o_event_code == EV_TEMP_OFF))
        else $error("missing off event");
    chk_wd_to_perm: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (st_q == ST_RUN && wd_perm) |=> perm ##1 !o_fail_status)
        else $error("watchdog fault not permanent");

    cov_event_on: cover property (@(posedge i_clk) disable iff (!i_arst_n)
        o_event_valid && o_event_code == EV_TEMP_ON);
    cov_event_off: cover property (@(posedge i_clk) disable iff (!i_arst_n)
        o_event_valid && o_event_code == EV_TEMP_OFF);
    cov_restart: cover property (@(posedge i_clk) disable iff (!i_arst_n)
        o_ctrl_restart ##[1:1000] (st_q == ST_RUN && kick));
    cov_perm: cover property (@(posedge i_clk) disable iff (!i_arst_n) $rose(perm));
endmodule : ssd_top

// ---- hdl/ssd_watchdog.sv ----
module ssd_watchdog #(
    parameter int TIMEOUT_CYC = 1000,
    parameter int RESTART_CYC = 4000,
    parameter int PULSE_CYC = 250
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_arst_n,
    // Controller supervision
    input wire logic i_enable,
    input wire logic i_kick,
    output logic o_restart,
    output logic o_perm
);
    import ssd_pkg::*;

    ssd_wd_state_t st_q;
    logic [31:0] cnt_q;

    // ************************************************************
    // Watch, restart, give up
    // ************************************************************
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st_q <= WD_WATCH;
            cnt_q <= 32'h0;
        end else begin
            case (st_q)
                WD_WATCH: begin
                    if (!i_enable || i_kick) begin
                        cnt_q <= 32'h0;
                    end else if (cnt_q == 32'(TIMEOUT_CYC - 1)) begin
                        st_q <= WD_RESTART;
                        cnt_q <= 32'h0;
                    end else begin
                        cnt_q <= cnt_q + 32'h1;
                    end
                end
                WD_RESTART: begin
                    if (i_kick) begin
                        st_q <= WD_WATCH;
                        cnt_q <= 32'h0;
                    end else if (cnt_q == 32'(RESTART_CYC - 1)) begin
                        st_q <= WD_DEAD;
                    end else begin
                        cnt_q <= cnt_q + 32'h1;
                    end
                end
                WD_DEAD: st_q <= WD_DEAD;
                default: st_q <= WD_WATCH;
            endcase
        end
    end

    // Restart pulse opens the window; the controller must then kick again
    assign o_restart = (st_q == WD_RESTART) && (cnt_q < 32'(PULSE_CYC));
    assign o_perm = (st_q == WD_DEAD);

    chk_wd_gives_up: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (st_q == WD_RESTART && cnt_q == 32'(RESTART_CYC - 1) && !i_kick) |=> o_perm [*2])
        else $error("watchdog did not flag permanent fault");
    chk_wd_restarts: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (st_q == WD_WATCH && i_enable && !i_kick && cnt_q == 32'(TIMEOUT_CYC - 1))
        |=> o_restart)
        else $error("watchdog timeout without restart");
endmodule : ssd_watchdog

// ---- tb/ssd_ctrl_model.sv ----
module ssd_ctrl_model (
    // Clock
    input wire logic i_clk,
    // Controller pins
    input wire logic i_alive,
    input wire logic i_restart,
    output logic o_heartbeat
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] cnt_q = 3'h0;
    logic beat_q = 1'b0;
    // Kick every eighth cycle; a hung controller stays silent even through a restart
    always_ff @(posedge i_clk) begin
        cnt_q <= cnt_q + 3'h1;
        if (i_alive && !i_restart && cnt_q == 3'h7) begin
            beat_q <= ~beat_q;
        end
    end
    assign o_heartbeat = beat_q;
endmodule : ssd_ctrl_model

// ---- tb/ssd_top_tb.sv ----
module ssd_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import ssd_pkg::*;
    // ****************************************
    // Bench signals
    // ****************************************
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic alive = 1'b1;
    logic sup = 1'b1;
    logic [N_GRP-1:0] sfl = 3'h2;
    logic [N_RELAY-1:0] rcmd = 24'hFFFFFF;
    logic hmi = 1'b0, load = 1'b0, rd = 1'b0, hb, restart, led, pnl, fail, tmp, evv, rv;
    logic [1:0] idx = 2'h0;
    logic [N_RELAY-1:0] rflt = '0, rdrv;
    logic [N_AUX-1:0] aflt = '0, adrv;
    logic [N_INT-1:0] iflt = '0;
    logic [N_SRC*GRP_W-1:0] grp = '0;
    logic [23:0] mtx = '0;
    logic [7:0] mout, ecode;
    logic [2:0] gact;
    logic [5:0] esrc;
    logic [15:0] rdata;
    int err_count = 0;
    int checked = 0;
    ssd_ctrl_model i_ssd_ctrl_model (.i_clk(clk), .i_alive(alive), .i_restart(restart),
        .o_heartbeat(hb));
    // Short watchdog counts keep the run brief
    ssd_top #(.WD_TIMEOUT(50), .WD_RESTART(400)) i_ssd_top (.i_clk(clk), .i_arst_n(rst_n),
        .i_heartbeat(hb), .i_boot_done(1'b1), .i_boot_pass(1'b1), .i_aux_supply_ok(sup),
        .o_ctrl_restart(restart), .i_relay_fault(rflt), .i_aux_fault(aflt),
        .i_internal_fault(iflt), .i_hmi_reset(hmi), .o_status_led(led), .o_panel_fault(pnl),
        .i_cfg_load(load), .i_cfg_group(grp), .i_cfg_sf_link(sfl), .i_cfg_matrix(mtx),
        .i_relay_cmd(rcmd), .i_aux_cmd(5'h1F), .o_relay_drive(rdrv), .o_aux_drive(adrv),
        .o_fail_status(fail), .o_group_active(gact), .o_matrix_out(mout), .o_temp_fault(tmp),
        .o_event_valid(evv), .o_event_code(ecode), .o_event_src(esrc), .i_reg_rd(rd),
        .i_reg_idx(idx), .o_reg_rdata(rdata), .o_reg_rvalid(rv));
    // Free-running clock
    initial begin
        forever #2 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : chk
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : give_verdict
    // Bounded wait; a pulse is caught because each edge's updates land first
    task automatic wait_hi(ref logic s, input int lim);
        int k;
        for (k = 0; k < lim && s !== 1'b1; k++) begin
            @(posedge clk);
            #1;
        end
        chk("wait", 32'(s), 32'h1);
        if (s !== 1'b1) give_verdict();
    endtask : wait_hi
    task automatic rdreg(input logic [1:0] i, input logic [15:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        idx <= i;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk("rvalid", 32'(rv), 32'h1);
        chk("rdata", 32'(rdata), 32'(exp));
    endtask : rdreg
    // Main sequence
    initial begin
        grp[1:0] = 2'h2;
        grp[49:48] = 2'h1;
        grp[59:58] = 2'h3;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (10) @(posedge clk);
        #1;
        chk("fail healthy", 32'(fail), 32'h1);
        chk("drive", 32'(rdrv), 32'hFFFFFF);
        chk("aux drive", 32'(adrv), 32'h1F);
        $display("test boot done");
        @(posedge clk);
        load <= 1'b1;
        mtx <= 24'h200000;
        @(posedge clk);
        load <= 1'b0;
        aflt <= 5'h01;
        wait_hi(evv, 12);
        chk("on code", 32'(ecode), 32'(EV_TEMP_ON));
        chk("on src", 32'(esrc), 32'(SRC_AUX_BASE));
        chk("temp on", 32'(tmp), 32'h1);
        repeat (3) @(posedge clk);
        #1;
        chk("group one", 32'(gact), 32'h1);
        chk("fail unlinked", 32'(fail), 32'h1);
        @(posedge clk);
        rflt <= 24'h800101;
        iflt <= 10'h2A5;
        repeat (6) @(posedge clk);
        #1;
        chk("groups", 32'(gact), 32'h7);
        chk("matrix", 32'(mout), 32'h20);
        chk("fail linked", 32'(fail), 32'h0);
        rdreg(IDX_RELAY_LO, 16'h8404);
        rdreg(IDX_RELAY_HI, 16'h4000);
        rdreg(IDX_SPARE, 16'h0000);
        rdreg(IDX_INTERNAL, 16'h02A5);
        $display("test faults done");
        @(posedge clk);
        rflt <= '0;
        aflt <= '0;
        iflt <= '0;
        wait_hi(evv, 12);
        chk("off code", 32'(ecode), 32'(EV_TEMP_OFF));
        chk("temp off", 32'(tmp), 32'h0);
        rdreg(IDX_RELAY_LO, 16'h8404);
        @(posedge clk);
        hmi <= 1'b1;
        @(posedge clk);
        hmi <= 1'b0;
        repeat (4) @(posedge clk);
        rdreg(IDX_INTERNAL, 16'h0000);
        chk("fail back", 32'(fail), 32'h1);
        // Supply loss must drop the fail output while commands still pass
        @(posedge clk);
        sup <= 1'b0;
        rcmd <= 24'h00A5A5;
        repeat (4) @(posedge clk);
        #1;
        chk("fail no supply", 32'(fail), 32'h0);
        chk("drive cmd", 32'(rdrv), 32'h00A5A5);
        @(posedge clk);
        sup <= 1'b1;
        $display("test clear done");
        @(posedge clk);
        alive <= 1'b0;
        wait_hi(restart, 200);
        wait_hi(led, 1000);
        chk("panel", 32'(pnl), 32'h1);
        chk("fail dropped", 32'(fail), 32'h0);
        chk("blocked", 32'(rdrv), 32'h0);
        chk("aux blocked", 32'(adrv), 32'h0);
        $display("test watchdog done");
        give_verdict();
    end
endmodule : ssd_top_tb
